// ---- shared/lca_pkg.sv ----
package lca_pkg;

   // ==========================================
   // Group geometry
   localparam int CELLS_PER_GROUP = 8;
   localparam int HALF_CELLS = 4;
   localparam int BITS_PER_CELL = 2;
   localparam int MAX_CHAIN_BITS = CELLS_PER_GROUP * BITS_PER_CELL;
   localparam int LUT_INPUTS = 6;
   localparam int LUT_SIZE = 64;
   localparam int UPPER_START = 0;
   localparam int LOWER_START = 4;
   localparam int UPPER_LAST = 3;
   localparam int LOWER_LAST = 7;

   // ==========================================
   // Cell operating modes
   typedef enum logic [2:0] {
      LCA_MODE_NORMAL = 3'h1,
      LCA_MODE_ARITH = 3'h2,
      LCA_MODE_SHARED = 3'h4
   } lca_mode_t;

   // ==========================================
   // Carry chain placement within a group
   typedef enum logic [3:0] {
      LCA_CHAIN_OFF = 4'h1,
      LCA_CHAIN_FULL = 4'h2,
      LCA_CHAIN_UPPER = 4'h4,
      LCA_CHAIN_LOWER = 4'h8
   } lca_chain_t;

   localparam logic RESET_BIT = 1'h0;

endpackage

// ---- verilog/lca_cell.sv ----
`timescale 1ns/1ps
module lca_cell (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Configuration
   input wire lca_pkg::lca_mode_t mode,
   input wire logic [lca_pkg::LUT_SIZE-1:0] lutMaskFirst,
   input wire logic [lca_pkg::LUT_SIZE-1:0] lutMaskSecond,
   input wire logic bypassFirst,
   input wire logic bypassSecond,
   // Data inputs
   input wire logic dataA,
   input wire logic dataB,
   input wire logic dataC,
   input wire logic dataD,
   input wire logic upperSelEFirst,
   input wire logic upperSelFFirst,
   input wire logic upperSelESecond,
   input wire logic upperSelFSecond,
   // Chains
   input wire logic carryIn,
   input wire logic sharedIn,
   output logic carryOut,
   output logic sharedOut,
   // Outputs
   output logic topOut,
   output logic secondOut
);

   logic firstFunc;
   logic secondFunc;
   logic midCarry;
   logic firstReg_q;
   logic firstReg_d;
   logic secondReg_q;
   logic secondReg_d;

   function automatic logic maj3(input logic x, input logic y, input logic z);
      maj3 = (x & y) | (x & z) | (y & z);
   endfunction

   function automatic logic lutRead(input logic [lca_pkg::LUT_SIZE-1:0] mask,
                                    input logic [lca_pkg::LUT_INPUTS-1:0] idx);
      lutRead = mask[idx];
   endfunction

   // ==========================================
   // Function and adder logic
   always_comb begin
      logic sumLutLo;
      logic sumLutHi;
      logic carLutLo;
      logic carLutHi;
      sumLutLo = dataA ^ dataB ^ dataC;
      carLutLo = maj3(dataA, dataB, dataC);
      sumLutHi = dataD ^ upperSelEFirst ^ upperSelESecond;
      carLutHi = maj3(dataD, upperSelEFirst, upperSelESecond);
      firstFunc = 1'h0;
      secondFunc = 1'h0;
      midCarry = 1'h0;
      carryOut = 1'h0;
      sharedOut = 1'h0;
      case (mode)
         lca_pkg::LCA_MODE_ARITH: begin
            firstFunc = dataA ^ dataB ^ carryIn;
            midCarry = maj3(dataA, dataB, carryIn);
            secondFunc = dataC ^ dataD ^ midCarry;
            carryOut = maj3(dataC, dataD, midCarry);
         end
         lca_pkg::LCA_MODE_SHARED: begin
            // Three operands reduce to sum plus shifted carry
            firstFunc = sumLutLo ^ sharedIn ^ carryIn;
            midCarry = maj3(sumLutLo, sharedIn, carryIn);
            secondFunc = sumLutHi ^ carLutLo ^ midCarry;
            carryOut = maj3(sumLutHi, carLutLo, midCarry);
            sharedOut = carLutHi;
         end
         default: begin
            // Both functions see the same a..d; only selects differ
            firstFunc = lutRead(lutMaskFirst, {upperSelFFirst, upperSelEFirst,
                                               dataD, dataC, dataB, dataA});
            secondFunc = lutRead(lutMaskSecond, {upperSelFSecond, upperSelESecond,
                                                 dataD, dataC, dataB, dataA});
         end
      endcase
   end

   // ==========================================
   // Output registers
   always_comb begin
      firstReg_d = firstFunc;
      secondReg_d = secondFunc;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         firstReg_q <= lca_pkg::RESET_BIT;
         secondReg_q <= lca_pkg::RESET_BIT;
      end else begin
         firstReg_q <= firstReg_d;
         secondReg_q <= secondReg_d;
      end
   end

   // Bypass trades a register stage for latency
   assign topOut = bypassFirst ? firstFunc : firstReg_q;
   assign secondOut = bypassSecond ? secondFunc : secondReg_q;

endmodule

// ---- verilog/lca_group.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Shared mode adds three operands per bit
// - Shared mode: four LUTs, sum or carry each
// - Shared carry feeds next adder, same group
// - Fast carry links adders in arithmetic modes
// - Chains start at cell one or five
// - Final carry-out lands in the registered finalCarry group output
// - Sixteen bits per group, then next group
// - Chains continue vertically up the column
// - Half chains carry into matching next half
// - Unused half stays in normal mode
// - Columns alternate top or bottom bypass
// - Five-input pairs share all four inputs a..d
// - Six-input pairs share four, same function
// - First select pair drives first register
// - Second select pair drives second register
module lca_group #(
   parameter int CELLS = lca_pkg::CELLS_PER_GROUP,
   parameter bit TOP_BYPASSABLE = 1'b1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Chain configuration
   input wire lca_pkg::lca_chain_t chainMode,
   input wire logic chainStart,
   input wire logic [CELLS-1:0] sharedSel,
   // Cell configuration
   input wire logic [CELLS-1:0][lca_pkg::LUT_SIZE-1:0] lutMaskFirst,
   input wire logic [CELLS-1:0][lca_pkg::LUT_SIZE-1:0] lutMaskSecond,
   input wire logic [CELLS-1:0] sixInPair,
   input wire logic [CELLS-1:0] bypassFirst,
   input wire logic [CELLS-1:0] bypassSecond,
   // Cell data
   input wire logic [CELLS-1:0] dataA,
   input wire logic [CELLS-1:0] dataB,
   input wire logic [CELLS-1:0] dataC,
   input wire logic [CELLS-1:0] dataD,
   input wire logic [CELLS-1:0] upperSelEFirst,
   input wire logic [CELLS-1:0] upperSelFFirst,
   input wire logic [CELLS-1:0] upperSelESecond,
   input wire logic [CELLS-1:0] upperSelFSecond,
   // Chain from and to neighbouring groups in the column
   input wire logic carryInUpper,
   input wire logic carryInLower,
   output logic carryOutUpper,
   output logic carryOutLower,
   // Results
   output logic [CELLS-1:0] topOut,
   output logic [CELLS-1:0] secondOut,
   output logic finalCarry,
   output logic cfgError,
   output logic [CELLS-1:0] packError
);

   logic [CELLS-1:0] inChain;
   logic [CELLS-1:0] cellCarryIn;
   logic [CELLS-1:0] cellSharedIn;
   logic [CELLS-1:0] cellCarryOut;
   logic [CELLS-1:0] cellSharedOut;
   lca_pkg::lca_mode_t cellMode [CELLS];
   lca_pkg::lca_chain_t effChain;
   logic chainEnd;
   logic finalCarry_q;
   logic finalCarry_d;
   logic cfgError_q;
   logic cfgError_d;
   logic [CELLS-1:0] packError_q;
   logic [CELLS-1:0] packError_d;

   function automatic logic isUpper(input int idx);
      isUpper = idx < lca_pkg::HALF_CELLS;
   endfunction

   // ==========================================
   // Chain placement
   always_comb begin
      effChain = chainMode;
      cfgError_d = 1'h0;
      // A half chain bypasses the other half; only one half per column may be skipped
      if (chainMode == lca_pkg::LCA_CHAIN_UPPER && TOP_BYPASSABLE) begin
         effChain = lca_pkg::LCA_CHAIN_OFF;
         cfgError_d = 1'h1;
      end else if (chainMode == lca_pkg::LCA_CHAIN_LOWER && !TOP_BYPASSABLE) begin
         effChain = lca_pkg::LCA_CHAIN_OFF;
         cfgError_d = 1'h1;
      end
      for (int i = 0; i < CELLS; i++) begin
         case (effChain)
            lca_pkg::LCA_CHAIN_FULL: inChain[i] = 1'h1;
            lca_pkg::LCA_CHAIN_UPPER: inChain[i] = isUpper(i);
            lca_pkg::LCA_CHAIN_LOWER: inChain[i] = !isUpper(i);
            default: inChain[i] = 1'h0;
         endcase
         if (!inChain[i]) begin
            cellMode[i] = lca_pkg::LCA_MODE_NORMAL;
         end else if (sharedSel[i]) begin
            cellMode[i] = lca_pkg::LCA_MODE_SHARED;
         end else begin
            cellMode[i] = lca_pkg::LCA_MODE_ARITH;
         end
         packError_d[i] = !inChain[i] && sixInPair[i] && (lutMaskFirst[i] != lutMaskSecond[i]);
      end
   end

   // ==========================================
   // Carry and shared-arithmetic links
   always_comb begin
      for (int i = 0; i < CELLS; i++) begin
         if (i == lca_pkg::UPPER_START) begin
            // Entry point only at cell one or cell five
            cellCarryIn[i] = chainStart ? 1'h0 : carryInUpper;
            cellSharedIn[i] = 1'h0;
         end else if (i == lca_pkg::LOWER_START && effChain == lca_pkg::LCA_CHAIN_LOWER) begin
            cellCarryIn[i] = chainStart ? 1'h0 : carryInLower;
            cellSharedIn[i] = 1'h0;
         end else begin
            cellCarryIn[i] = cellCarryOut[i-1];
            cellSharedIn[i] = cellSharedOut[i-1];
         end
      end
      carryOutUpper = 1'h0;
      carryOutLower = 1'h0;
      chainEnd = 1'h0;
      case (effChain)
         lca_pkg::LCA_CHAIN_FULL: begin
            carryOutUpper = cellCarryOut[lca_pkg::LOWER_LAST];
            chainEnd = cellCarryOut[lca_pkg::LOWER_LAST];
         end
         lca_pkg::LCA_CHAIN_UPPER: begin
            carryOutUpper = cellCarryOut[lca_pkg::UPPER_LAST];
            chainEnd = cellCarryOut[lca_pkg::UPPER_LAST];
         end
         lca_pkg::LCA_CHAIN_LOWER: begin
            carryOutLower = cellCarryOut[lca_pkg::LOWER_LAST];
            chainEnd = cellCarryOut[lca_pkg::LOWER_LAST];
         end
         default: chainEnd = 1'h0;
      endcase
      finalCarry_d = chainEnd;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         finalCarry_q <= lca_pkg::RESET_BIT;
         cfgError_q <= lca_pkg::RESET_BIT;
         packError_q <= '0;
      end else begin
         finalCarry_q <= finalCarry_d;
         cfgError_q <= cfgError_d;
         packError_q <= packError_d;
      end
   end

   assign finalCarry = finalCarry_q;
   assign cfgError = cfgError_q;
   assign packError = packError_q;

   // ==========================================
   // Cells
   for (genvar g = 0; g < CELLS; g++) begin : gCell
      lca_cell uCell (
         .ref_clk(ref_clk),
         .rstn(rstn),
         .mode(cellMode[g]),
         .lutMaskFirst(lutMaskFirst[g]),
         .lutMaskSecond(lutMaskSecond[g]),
         .bypassFirst(bypassFirst[g]),
         .bypassSecond(bypassSecond[g]),
         .dataA(dataA[g]),
         .dataB(dataB[g]),
         .dataC(dataC[g]),
         .dataD(dataD[g]),
         .upperSelEFirst(upperSelEFirst[g]),
         .upperSelFFirst(upperSelFFirst[g]),
         .upperSelESecond(upperSelESecond[g]),
         .upperSelFSecond(upperSelFSecond[g]),
         .carryIn(cellCarryIn[g]),
         .sharedIn(cellSharedIn[g]),
         .carryOut(cellCarryOut[g]),
         .sharedOut(cellSharedOut[g]),
         .topOut(topOut[g]),
         .secondOut(secondOut[g])
      );
   end

endmodule

// ---- verif/lca_prev_group.sv ----
`timescale 1ns/1ps
// ==========
// Previous group in the column, seen only through its carries
module lca_prev_group (
   // Chain setup
   input logic en,
   input logic half,
   input logic [15:0] opX,
   input logic [15:0] opY,
   // Carries towards the next group
   output logic carryUpper,
   output logic carryLower
);
   logic [16:0] fullSum;
   logic [8:0] halfSum;
   assign fullSum = opX + opY;
   assign halfSum = opX[7:0] + opY[7:0];
   // Only the lane in use may carry
   assign carryUpper = en && !half && fullSum[16];
   assign carryLower = en && half && halfSum[8];
endmodule

// ---- verif/lca_group_sva.sv ----
`timescale 1ns/1ps
// ==========
// Port checks for one group
module lca_group_sva #(parameter bit TOP_BYPASSABLE = 1'b1) (
   // Clock, reset, setup
   input logic ref_clk, rstn, chainStart,
   input lca_pkg::lca_chain_t chainMode,
   input logic [7:0][63:0] lutMaskFirst, lutMaskSecond,
   input logic [7:0] sharedSel, sixInPair, bypassFirst, bypassSecond, dataA, dataB, dataC, dataD,
   input logic [7:0] upperSelEFirst, upperSelFFirst, upperSelESecond, upperSelFSecond,
   // Results
   input logic carryOutUpper, carryOutLower, finalCarry, cfgError,
   input logic [7:0] topOut, secondOut, packError
);
   localparam lca_pkg::lca_chain_t OF = lca_pkg::LCA_CHAIN_OFF;
   localparam lca_pkg::lca_chain_t FU = lca_pkg::LCA_CHAIN_FULL;
   localparam lca_pkg::lca_chain_t LO = lca_pkg::LCA_CHAIN_LOWER;
   localparam lca_pkg::lca_chain_t BAD = TOP_BYPASSABLE ? lca_pkg::LCA_CHAIN_UPPER : LO;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_off; chainMode == OF |-> !carryOutUpper && !carryOutLower ##1 !finalCarry; endproperty
   a_off: assert property (p_off) else $error("carry with chain off");
   property p_full; chainMode == FU |=> finalCarry == $past(carryOutUpper); endproperty
   a_full: assert property (p_full) else $error("full chain end carry");
   property p_low; chainMode == LO |-> !carryOutUpper ##1 !cfgError && finalCarry == $past(carryOutLower); endproperty
   a_low: assert property (p_low) else $error("lower half chain");
   property p_bad; chainMode == BAD |-> !carryOutUpper && !carryOutLower ##1 cfgError; endproperty
   a_bad: assert property (p_bad) else $error("half chain not refused");
   property p_end; chainMode == FU |=> !cfgError; endproperty
   a_end: assert property (p_end) else $error("full chain refused");
   property p_start; chainMode == FU && chainStart && !sharedSel[0] && bypassFirst[0]
      |-> topOut[0] == (dataA[0] ^ dataB[0]); endproperty
   a_start: assert property (p_start) else $error("chain start carry");
   property p_lut1; chainMode == OF && bypassFirst[0] |-> topOut[0] == lutMaskFirst[0][{upperSelFFirst[0],
      upperSelEFirst[0], dataD[0], dataC[0], dataB[0], dataA[0]}]; endproperty
   a_lut1: assert property (p_lut1) else $error("first function output");
   // Registered path only: a bypassed output shows the new cycle's inputs
   property p_lut2; chainMode == OF ##1 !bypassSecond[1] |-> secondOut[1] == $past(lutMaskSecond[1][{upperSelFSecond[1],
      upperSelESecond[1], dataD[1], dataC[1], dataB[1], dataA[1]}]) || !$past(rstn); endproperty
   a_lut2: assert property (p_lut2) else $error("second function output");
   property p_pack; chainMode == OF && sixInPair[0] && lutMaskFirst[0] != lutMaskSecond[0] |=> packError[0]; endproperty
   a_pack: assert property (p_pack) else $error("pack error missing");
   cover property (chainMode == FU && !chainStart);
   cover property (chainMode == LO && !chainStart);
   cover property (cfgError);
endmodule
bind lca_group lca_group_sva #(.TOP_BYPASSABLE(TOP_BYPASSABLE)) u_sva (.*);

// ---- verif/lca_group_tb.sv ----
`timescale 1ns/1ps
module lca_group_tb;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   lca_pkg::lca_chain_t chainMode = lca_pkg::LCA_CHAIN_OFF;
   logic chainStart = 1'b0;
   logic [7:0] sharedSel = 8'h00, sixInPair = 8'h00, bypassFirst = 8'h00, bypassSecond = 8'h00;
   logic [7:0] dataA = 8'h00, dataB = 8'h00, dataC = 8'h00, dataD = 8'h00;
   logic [7:0] upperSelEFirst = 8'h00, upperSelFFirst = 8'h00, upperSelESecond = 8'h00, upperSelFSecond = 8'h00;
   logic [7:0][63:0] lutMaskFirst = '0, lutMaskSecond = '0;
   logic carryInUpper, carryInLower, carryOutUpper, carryOutLower, finalCarry, cfgError;
   logic [7:0] topOut, secondOut, packError;
   logic pEn = 1'b0, pHalf = 1'b0;
   logic [15:0] pX = 16'h0000, pY = 16'h0000;
   int seed = 32'he2e9;
   int mismatches = 0;
   int check_count = 0;
   always #12.5 ref_clk = ~ref_clk;
   lca_prev_group u_prev (.en(pEn), .half(pHalf), .opX(pX), .opY(pY), .carryUpper(carryInUpper),
      .carryLower(carryInLower));
   lca_group u_dut (.*);
   // ==========
   // Checking
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Arith: even bits A+B, odd C+D; shared: even A+B+C, odd D+E1+E2
   function automatic int addv(int lo, int n, logic cin, logic sh);
      int x, y, z, i;
      x = 0;
      y = 0;
      z = 0;
      for (int k = 0; k < 2 * n; k++) begin
         i = lo + k / 2;
         x += int'(k % 2 ? (sh ? dataD[i] : dataC[i]) : dataA[i]) << k;
         y += int'(k % 2 ? (sh ? upperSelEFirst[i] : dataD[i]) : dataB[i]) << k;
         z += int'(sh && (k % 2 ? upperSelESecond[i] : dataC[i])) << k;
      end
      return x + y + z + int'(cin);
   endfunction
   // ==========
   // One cycle of random stimulus in a chosen mode
   task automatic run_case(int sel, bit corner);
      int s, lo, n;
      logic cin;
      logic [7:0] eTop, eSec, ePack;
      @(negedge ref_clk);
      case (sel)
         0, 1: chainMode = lca_pkg::LCA_CHAIN_FULL;
         2: chainMode = lca_pkg::LCA_CHAIN_LOWER;
         3: chainMode = lca_pkg::LCA_CHAIN_OFF;
         default: chainMode = lca_pkg::LCA_CHAIN_UPPER;
      endcase
      n = sel < 2 ? 8 : (sel == 2 ? 4 : 0);
      lo = n == 4 ? 4 : 0;
      {dataA, dataB, dataC, dataD} = $random(seed);
      {upperSelEFirst, upperSelFFirst, upperSelESecond, upperSelFSecond} = $random(seed);
      {bypassFirst, bypassSecond, sixInPair, chainStart} = 25'($random(seed));
      sixInPair = sel > 2 ? sixInPair : 8'h00;
      chainStart = chainStart | (sel == 1);
      sharedSel = sel == 1 ? 8'hff : 8'h00;
      for (int i = 0; i < 8; i++) begin
         lutMaskFirst[i] = {$random(seed), $random(seed)};
         lutMaskSecond[i] = i % 2 ? lutMaskFirst[i] : {$random(seed), $random(seed)};
      end
      {pX, pY} = $random(seed);
      pEn = 1'b1;
      pHalf = n == 4;
      // Carry must ripple through every bit of the group
      if (corner) begin
         {dataA, dataC, dataB, dataD, chainStart} = {16'hffff, 17'h00000};
         {pX, pY} = {16'hffff, 16'h0001};
      end
      #1;
      cin = !chainStart && (lo ? carryInLower : carryInUpper);
      s = addv(lo, n, cin, sel == 1);
      for (int i = 0; i < 8; i++) begin
         eTop[i] = lutMaskFirst[i][{upperSelFFirst[i], upperSelEFirst[i], dataD[i], dataC[i], dataB[i], dataA[i]}];
         eSec[i] = lutMaskSecond[i][{upperSelFSecond[i], upperSelESecond[i], dataD[i], dataC[i], dataB[i], dataA[i]}];
         ePack[i] = sixInPair[i] && lutMaskFirst[i] != lutMaskSecond[i];
         if (i >= lo && i < lo + n) begin
            eTop[i] = s[2 * (i - lo)];
            eSec[i] = s[2 * (i - lo) + 1];
         end
      end
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(17'(topOut), 17'(eTop));
      chk(17'(secondOut), 17'(eSec));
      chk(17'({packError, cfgError}), 17'({ePack, sel == 4}));
      if (sel != 1) begin
         chk(17'({carryOutUpper, carryOutLower, finalCarry}), 17'({n == 8, n == 4, n > 0} & {3{s[2 * n]}}));
      end
   endtask
   initial begin
      repeat (5) @(negedge ref_clk);
      chk(17'({topOut, finalCarry}), 17'h00000);
      rstn = 1'b1;
      for (int sel = 0; sel < 5; sel++) begin
         run_case(sel, 1'b0);
      end
      run_case(0, 1'b1);
      repeat (60) begin
         run_case($unsigned($random(seed)) % 5, 1'b0);
      end
      complete_run();
   end
endmodule
